// [design/pll_regs_pkg.sv]
// constants for the loop bandwidth and programming register block
package pll_regs_pkg;
  localparam int          ADDR_W          = 2;       // register address width
  localparam int          DATA_W          = 8;       // register data width
  // register offsets
  localparam logic [1:0]  OFS_LOOP_CTRL   = 2'h0;    // loop_ctrl_reg
  localparam logic [1:0]  OFS_BANDWIDTH   = 2'h1;    // bandwidth_ctrl_reg
  localparam logic [1:0]  OFS_PROGRAM     = 2'h2;    // loop_program_reg
  localparam logic [1:0]  OFS_VCO_RANGE   = 2'h3;    // vco range register
  // loop_ctrl_reg fields
  localparam int          BIT_IRQ_EN      = 7;       // loop_irq_enable
  localparam int          BIT_CHG_FLAG    = 6;       // loop_change_flag
  localparam int          BIT_POWER_ON    = 5;       // loop_power_on
  localparam int          BIT_BASE_SEL    = 4;       // base_source_select
  localparam logic [3:0]  CTRL_UNUSED_RD  = 4'hf;    // unused low bits read ones
  // bandwidth_ctrl_reg fields
  localparam int          BIT_AUTO        = 7;       // automatic bandwidth mode
  localparam int          BIT_LOCK        = 6;       // lock indication
  localparam int          BIT_TRACK       = 5;       // tracking_select
  localparam int          BIT_REF_LOSS    = 4;       // ref_loss_detect
  // field positions in loop_program_reg and vco range register
  localparam int          FIELD_HI        = 7;       // top bit of 4-bit field
  localparam int          FIELD_LO        = 4;       // low bit of 4-bit field
  // values after reset and special field codes
  localparam logic [3:0]  RST_FACTOR      = 4'h6;    // feedback_factor
  localparam logic [3:0]  RST_RANGE       = 4'h6;    // vco_range_field
  localparam logic        RST_POWER_ON    = 1'b1;    // loop powered at reset
  localparam logic [3:0]  FACTOR_ZERO     = 4'h0;    // pattern acting as one
  localparam logic [3:0]  FACTOR_ONE      = 4'h1;    // effective factor for zero
  localparam logic [3:0]  RANGE_OFF       = 4'h0;    // range value disabling loop
  // base clock changeover stasis
  localparam int          HOLD_SRC_CYCLES = 3;       // cycles per source clock
  localparam int          HOLD_CYCLES     = 2 * HOLD_SRC_CYCLES;  // both sources
  localparam logic [2:0]  HOLD_LOAD       = 3'(HOLD_CYCLES);     // counter load
endpackage : pll_regs_pkg

// [design/bit_sync.sv]
// two flip-flop synchroniser for a group of level inputs
module bit_sync #(
  parameter int WIDTH = 1                // number of bits carried
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;              // first stage, read only by second

  // refuse a zero width
  if (WIDTH < 1) begin : g_chk
    $error("bit_sync: WIDTH must be at least 1");
  end

  // two stages, cleared by reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule : bit_sync

// [design/pll_bandwidth_program_regs.sv]
// register side control and status logic of the loop clock generator
module pll_bandwidth_program_regs
  import pll_regs_pkg::*;
(
  // clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          rst_i,
  // register port
  input  wire logic [pll_regs_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [pll_regs_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                          reg_write_i,
  input  wire logic                          reg_read_i,
  output logic      [pll_regs_pkg::DATA_W-1:0] reg_rdata_o,
  // status from the analog loop and oscillator
  input  wire logic                          loop_locked_i,
  input  wire logic                          loop_in_track_tol_i,
  input  wire logic                          crystal_clock_i,
  // controls to the analog loop and clock switch
  output logic                               loop_power_on_o,
  output logic                               base_source_select_o,
  output logic                               base_clock_hold_o,
  output logic                               tracking_mode_o,
  output logic                               auto_mode_o,
  output logic      [3:0]                    feedback_factor_o,
  output logic      [3:0]                    vco_range_field_o,
  // interrupt request to the cpu
  output logic                               loop_irq_o
);
  import pll_regs_pkg::*;

  // software visible state, stasis counter and history
  logic       irq_enable_r;              // loop_irq_enable
  logic       change_flag_r;             // loop_change_flag
  logic       power_on_r;                // loop_power_on
  logic       base_sel_r;                // base_source_select
  logic       auto_r;                    // automatic bandwidth mode
  logic       manual_track_r;            // hidden manual tracking value
  logic       ref_loss_r;                // ref_loss_detect
  logic [3:0] factor_r;                  // feedback_factor
  logic [3:0] range_r;                   // vco_range_field
  logic [2:0] hold_cnt_r;                // changeover stasis counter
  logic       lock_prev_r;               // lock seen last cycle
  logic       xtal_prev_r;               // crystal level last cycle
  logic [DATA_W-1:0] rdata_r;            // registered read data

  // next values
  logic       irq_enable_nxt;
  logic       change_flag_nxt;
  logic       power_on_nxt;
  logic       base_sel_nxt;
  logic       auto_nxt;
  logic       manual_track_nxt;
  logic       ref_loss_nxt;
  logic [3:0] factor_nxt;
  logic [3:0] range_nxt;
  logic [2:0] hold_cnt_nxt;
  logic [DATA_W-1:0] rdata_nxt;

  // synchronised pin levels
  logic [2:0] pins_sync;                 // {crystal, track tol, locked}
  wire        lock_s  = pins_sync[0];    // lock level, synchronised
  wire        track_s = pins_sync[1];    // tracking tolerance met
  wire        xtal_s  = pins_sync[2];    // crystal level, synchronised

  // pin inputs pass two flip-flops first
  bit_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i ({crystal_clock_i, loop_in_track_tol_i, loop_locked_i}),
    .sync_o  (pins_sync)
  );

  // address decode
  wire wr_ctrl  = reg_write_i && (reg_addr_i == OFS_LOOP_CTRL);   // control write
  wire wr_bw    = reg_write_i && (reg_addr_i == OFS_BANDWIDTH);   // bandwidth write
  wire wr_prog  = reg_write_i && (reg_addr_i == OFS_PROGRAM);     // programming write
  wire wr_range = reg_write_i && (reg_addr_i == OFS_VCO_RANGE);   // range write
  wire rd_ctrl  = reg_read_i && (reg_addr_i == OFS_LOOP_CTRL);    // control read

  // derived status
  wire range_off   = (range_r == RANGE_OFF);
  wire lock_view   = auto_r && lock_s;
  wire track_view  = auto_r ? track_s : manual_track_r;
  wire flag_view   = auto_r && change_flag_r;
  wire lock_change = auto_r && (lock_s != lock_prev_r);
  wire xtal_edge   = (xtal_s != xtal_prev_r);                     // crystal alive
  wire ref_view    = base_sel_r && ref_loss_r;

  // field read views
  wire [DATA_W-1:0] ctrl_view = {irq_enable_r && auto_r, flag_view, power_on_r, base_sel_r, CTRL_UNUSED_RD};
  wire [DATA_W-1:0] bw_view   = {auto_r, lock_view, track_view, ref_view, 4'h0};
  wire [DATA_W-1:0] prog_view = {factor_r, 4'h0};
  wire [DATA_W-1:0] rng_view  = {range_r, 4'h0};

  // outputs to the loop, clock switch, cpu and register port
  assign loop_power_on_o      = power_on_r && !range_off;
  assign base_source_select_o = base_sel_r;
  assign base_clock_hold_o    = (hold_cnt_r != 3'h0);
  assign tracking_mode_o      = track_view;
  assign auto_mode_o          = auto_r;
  assign feedback_factor_o    = (factor_r == FACTOR_ZERO) ? FACTOR_ONE : factor_r;
  assign vco_range_field_o    = range_r;
  assign loop_irq_o           = auto_r && irq_enable_r && change_flag_r;
  assign reg_rdata_o          = rdata_r;

  // control register write handling, protections applied
  always_comb begin
    irq_enable_nxt = irq_enable_r;
    power_on_nxt   = power_on_r;
    base_sel_nxt   = base_sel_r;
    if (wr_ctrl) begin
      // enable writable only in auto mode
      if (auto_r) begin
        irq_enable_nxt = reg_wdata_i[BIT_IRQ_EN];
      end
      // power cannot drop while vco selected
      if (!(base_sel_r && !reg_wdata_i[BIT_POWER_ON])) begin
        power_on_nxt = reg_wdata_i[BIT_POWER_ON];
      end
      // select refused without power or range; lock not required
      if (reg_wdata_i[BIT_BASE_SEL] && (!power_on_nxt || range_off)) begin
        base_sel_nxt = base_sel_r;
      end else begin
        base_sel_nxt = reg_wdata_i[BIT_BASE_SEL];
      end
    end
    // zero range clears the select at once
    if (range_off) begin
      base_sel_nxt = 1'b0;
    end
    // manual mode forces enable low
    if (!auto_nxt) begin
      irq_enable_nxt = 1'b0;
    end
  end

  // bandwidth register write handling
  always_comb begin
    auto_nxt         = auto_r;
    manual_track_nxt = manual_track_r;
    ref_loss_nxt     = ref_loss_r;
    if (wr_bw) begin
      auto_nxt = reg_wdata_i[BIT_AUTO];
      // tracking bit writable only in manual mode, kept during auto
      if (!auto_r) begin
        manual_track_nxt = reg_wdata_i[BIT_TRACK];
      end
    end
    // crystal edge clears the check, a write of one arms it
    if (xtal_edge) begin
      ref_loss_nxt = 1'b0;
    end
    if (wr_bw && reg_wdata_i[BIT_REF_LOSS] && base_sel_r) begin
      ref_loss_nxt = 1'b1;
    end
    // check disarmed when crystal drives the base clock
    if (!base_sel_r) begin
      ref_loss_nxt = 1'b0;
    end
  end

  // programming and range fields, locked while powered
  always_comb begin
    factor_nxt = factor_r;
    range_nxt  = range_r;
    if (wr_prog && !power_on_r) begin
      factor_nxt = reg_wdata_i[FIELD_HI:FIELD_LO];
    end
    if (wr_range && !power_on_r) begin
      range_nxt = reg_wdata_i[FIELD_HI:FIELD_LO];
    end
  end

  // change flag: lock change wins over the read clear
  always_comb begin
    if (!auto_r) begin
      change_flag_nxt = 1'b0;
    end else if (lock_change) begin
      change_flag_nxt = 1'b1;
    end else if (rd_ctrl) begin
      change_flag_nxt = 1'b0;
    end else begin
      change_flag_nxt = change_flag_r;
    end
  end

  // changeover stasis counter
  always_comb begin
    if (base_sel_nxt != base_sel_r) begin
      hold_cnt_nxt = HOLD_LOAD;
    end else if (hold_cnt_r != 3'h0) begin
      hold_cnt_nxt = hold_cnt_r - 3'h1;
    end else begin
      hold_cnt_nxt = hold_cnt_r;
    end
  end

  // read data select
  always_comb begin
    case (reg_addr_i)
      OFS_LOOP_CTRL: rdata_nxt = ctrl_view;
      OFS_BANDWIDTH: rdata_nxt = bw_view;
      OFS_PROGRAM:   rdata_nxt = prog_view;
      OFS_VCO_RANGE: rdata_nxt = rng_view;
      default:       rdata_nxt = '0;
    endcase
    if (!reg_read_i) begin
      rdata_nxt = '0;
    end
  end

  // control state; only bus accesses and loop status move it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_enable_r  <= 1'b0;
      change_flag_r <= 1'b0;
      power_on_r    <= RST_POWER_ON;
      base_sel_r    <= 1'b0;
    end else begin
      irq_enable_r  <= irq_enable_nxt;
      change_flag_r <= change_flag_nxt;
      power_on_r    <= power_on_nxt;
      base_sel_r    <= base_sel_nxt;
    end
  end

  // bandwidth state
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      auto_r         <= 1'b0;
      manual_track_r <= 1'b0;
      ref_loss_r     <= 1'b0;
    end else begin
      auto_r         <= auto_nxt;
      manual_track_r <= manual_track_nxt;
      ref_loss_r     <= ref_loss_nxt;
    end
  end

  // programming fields
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      factor_r <= RST_FACTOR;
      range_r  <= RST_RANGE;
    end else begin
      factor_r <= factor_nxt;
      range_r  <= range_nxt;
    end
  end

  // history, stasis and read data
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hold_cnt_r  <= 3'h0;
      lock_prev_r <= 1'b0;
      xtal_prev_r <= 1'b0;
      rdata_r     <= '0;
    end else begin
      hold_cnt_r  <= hold_cnt_nxt;
      lock_prev_r <= lock_s;
      xtal_prev_r <= xtal_s;
      rdata_r     <= rdata_nxt;
    end
  end
endmodule : pll_bandwidth_program_regs

// [sim/pll_regs_checker_asserts.sv]
// assertion checker for the loop register block
module pll_regs_checker
  import pll_regs_pkg::*;
(
  // clock and reset
  input  wire logic                            clock_i,
  input  wire logic                            rst_i,
  // register port
  input  wire logic [pll_regs_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic                            reg_write_i,
  input  wire logic                            reg_read_i,
  input  wire logic [pll_regs_pkg::DATA_W-1:0] reg_rdata_o,
  // loop side
  input  wire logic                            loop_in_track_tol_i,
  input  wire logic                            loop_power_on_o,
  input  wire logic                            base_source_select_o,
  input  wire logic                            base_clock_hold_o,
  input  wire logic                            tracking_mode_o,
  input  wire logic                            auto_mode_o,
  input  wire logic [3:0]                      feedback_factor_o,
  input  wire logic [3:0]                      vco_range_field_o,
  input  wire logic                            loop_irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // decoded accesses
  wire wr_prog  = reg_write_i && reg_addr_i == OFS_PROGRAM;   // program write
  wire wr_range = reg_write_i && reg_addr_i == OFS_VCO_RANGE; // range write
  wire rd_ctrl  = reg_read_i && reg_addr_i == OFS_LOOP_CTRL;  // control read

  chk_irq_auto: assert property (loop_irq_o |-> auto_mode_o)
    else $error("loop irq outside auto mode");
  chk_sel_power: assert property (base_source_select_o |-> loop_power_on_o && vco_range_field_o != RANGE_OFF)
    else $error("vco source without running loop");
  chk_factor_min: assert property (feedback_factor_o != FACTOR_ZERO)
    else $error("factor shows zero");
  chk_factor_keep: assert property (wr_prog && loop_power_on_o |=> $stable(feedback_factor_o))
    else $error("factor changed while powered");
  chk_range_keep: assert property (wr_range && loop_power_on_o |=> $stable(vco_range_field_o))
    else $error("range changed while powered");
  chk_track_auto: assert property (auto_mode_o && $past(auto_mode_o, 3) |-> tracking_mode_o == $past(loop_in_track_tol_i, 2))
    else $error("tracking does not follow loop");
  chk_hold_len: assert property ($changed(base_source_select_o) |-> base_clock_hold_o [*6] ##1 !base_clock_hold_o)
    else $error("changeover hold length wrong");
  chk_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == '0)
    else $error("read data outside read cycle");
  chk_flag_manual: assert property (rd_ctrl && !auto_mode_o |=> reg_rdata_o[7:6] == 2'h0)
    else $error("flag or enable visible in manual");

  // main scenarios reached
  cover property (loop_irq_o);
  cover property ($rose(base_source_select_o));
  cover property (wr_prog && loop_power_on_o);
endmodule : pll_regs_checker

bind pll_bandwidth_program_regs pll_regs_checker u_pll_regs_checker (.*);

// [sim/test_pll_bandwidth_program_regs.sv]
// self-checking bench for the loop register block
module test_pll_bandwidth_program_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import pll_regs_pkg::*;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
  // design ports
  logic              clock_i;              // bus clock
  logic              rst_i;                // synchronous reset
  logic [ADDR_W-1:0] reg_addr_i;           // register index
  logic [DATA_W-1:0] reg_wdata_i;          // write data
  logic              reg_write_i;          // write strobe
  logic              reg_read_i;           // read strobe
  logic [DATA_W-1:0] reg_rdata_o;          // read data
  logic              loop_locked_i;        // lock level
  logic              loop_in_track_tol_i;  // tracking tolerance
  logic              crystal_clock_i;      // crystal level
  logic              loop_power_on_o;      // loop powered
  logic              base_source_select_o; // vco source
  logic              base_clock_hold_o;    // changeover hold
  logic              tracking_mode_o;      // tracking mode
  logic              auto_mode_o;          // auto bandwidth
  logic [3:0]        feedback_factor_o;    // effective factor
  logic [3:0]        vco_range_field_o;    // range field
  logic              loop_irq_o;           // interrupt
  // bench state
  logic              xtal_run;             // crystal toggling
  logic              rd_d;                 // read taken last edge
  logic [15:0]       exp_q[$];             // mask and value per read
  logic [15:0]       exp_e;                // note being compared
  logic [3:0]        v;                    // random factor
  int                fail_count;           // mismatches
  int                check_count;          // comparisons
  int                cycles;               // timeout count

  pll_bandwidth_program_regs u_pll_bandwidth_program_regs (.*);

  // bus clock, 40 ns
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // crystal toggles when running, read pipe, timeout
  always @(posedge clock_i) begin
    if (xtal_run) crystal_clock_i <= ~crystal_clock_i;
    rd_d <= reg_read_i;
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      print_verdict();
    end
  end

  // compare read data with oldest note
  always @(negedge clock_i) begin
    if (rd_d) begin
      exp_e = exp_q.pop_front();
      `CHK(reg_rdata_o & exp_e[15:8], exp_e[7:0])
    end
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge clock_i);
    reg_read_i <= 1'b0;
  endtask : rd

  // wait n edges, then settle to falling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask : cyc

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end
    else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    {rst_i, reg_addr_i, reg_wdata_i, reg_write_i, reg_read_i} = {1'b1, 12'h0};
    {loop_locked_i, loop_in_track_tol_i, crystal_clock_i, xtal_run, rd_d} = 5'h0;
    {fail_count, check_count, cycles} = 0;
    void'($urandom(32'h3af8));
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(OFS_LOOP_CTRL, 8'hff, 8'h2f);
    rd(OFS_BANDWIDTH, 8'hff, 8'h00);
    rd(OFS_PROGRAM, 8'hf0, 8'h60);
    rd(OFS_VCO_RANGE, 8'hf0, 8'h60);
    $display("test reset values done");
    wr(OFS_PROGRAM, 8'h30);
    wr(OFS_VCO_RANGE, 8'h20);
    rd(OFS_PROGRAM, 8'hf0, 8'h60);
    rd(OFS_VCO_RANGE, 8'hf0, 8'h60);
    wr(OFS_LOOP_CTRL, 8'h00);
    wr(OFS_LOOP_CTRL, 8'h10);
    rd(OFS_LOOP_CTRL, 8'hff, 8'h0f);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 4'h0 : 4'($urandom());
      wr(OFS_PROGRAM, {v, 4'h0});
      cyc(0);
      `CHK(feedback_factor_o, (v == 4'h0) ? 4'h1 : v)
    end
    wr(OFS_VCO_RANGE, 8'h00);
    wr(OFS_LOOP_CTRL, 8'h30);
    cyc(0);
    `CHK({base_source_select_o, loop_power_on_o}, 2'h0)
    wr(OFS_LOOP_CTRL, 8'h00);
    wr(OFS_VCO_RANGE, 8'h40);
    wr(OFS_PROGRAM, 8'h20);
    wr(OFS_LOOP_CTRL, 8'h20);
    wr(OFS_LOOP_CTRL, 8'h30);
    cyc(0);
    `CHK(base_source_select_o, 1'b1)
    wr(OFS_LOOP_CTRL, 8'h10);
    rd(OFS_LOOP_CTRL, 8'hff, 8'h3f);
    $display("test protection done");
    wr(OFS_BANDWIDTH, 8'h10);
    cyc(8);
    rd(OFS_BANDWIDTH, 8'h10, 8'h10);
    xtal_run <= 1'b1;
    wr(OFS_BANDWIDTH, 8'h10);
    cyc(8);
    rd(OFS_BANDWIDTH, 8'h10, 8'h00);
    wr(OFS_LOOP_CTRL, 8'h20);
    wr(OFS_BANDWIDTH, 8'h10);
    cyc(8);
    rd(OFS_BANDWIDTH, 8'h10, 8'h00);
    xtal_run <= 1'b0;
    $display("test reference check done");
    wr(OFS_BANDWIDTH, 8'h20);
    cyc(0);
    `CHK(tracking_mode_o, 1'b1)
    rd(OFS_BANDWIDTH, 8'he0, 8'h20);
    wr(OFS_BANDWIDTH, 8'ha0);
    @(posedge clock_i);
    loop_in_track_tol_i <= 1'b1;
    cyc(4);
    `CHK(tracking_mode_o, 1'b1)
    rd(OFS_BANDWIDTH, 8'ha0, 8'ha0);
    loop_in_track_tol_i <= 1'b0;
    cyc(4);
    `CHK(tracking_mode_o, 1'b0)
    wr(OFS_BANDWIDTH, 8'h00);
    cyc(0);
    `CHK(tracking_mode_o, 1'b1)
    wr(OFS_BANDWIDTH, 8'h00);
    cyc(0);
    `CHK(tracking_mode_o, 1'b0)
    $display("test tracking done");
    wr(OFS_BANDWIDTH, 8'h80);
    wr(OFS_LOOP_CTRL, 8'h20);
    rd(OFS_LOOP_CTRL, 8'h00, 8'h00);
    loop_locked_i <= 1'b1;
    cyc(5);
    rd(OFS_BANDWIDTH, 8'h40, 8'h40);
    cyc(0);
    `CHK(loop_irq_o, 1'b0)
    rd(OFS_LOOP_CTRL, 8'h40, 8'h40);
    rd(OFS_LOOP_CTRL, 8'h40, 8'h00);
    wr(OFS_LOOP_CTRL, 8'ha0);
    loop_locked_i <= 1'b0;
    cyc(5);
    `CHK(loop_irq_o, 1'b1)
    rd(OFS_BANDWIDTH, 8'h40, 8'h00);
    rd(OFS_LOOP_CTRL, 8'hc0, 8'hc0);
    cyc(1);
    `CHK(loop_irq_o, 1'b0)
    wr(OFS_BANDWIDTH, 8'h00);
    loop_locked_i <= 1'b1;
    cyc(5);
    rd(OFS_LOOP_CTRL, 8'hc0, 8'h00);
    cyc(1);
    `CHK(loop_irq_o, 1'b0)
    $display("test interrupt done");
    cyc(2);
    print_verdict();
  end
endmodule : test_pll_bandwidth_program_regs
